// ### srdr_pkg.sv
// Shared constants, register map and types of the safe-run dwell ramp block
package srdr_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 25;          // 40 MHz control clock
    localparam int unsigned TENTH_S_NS    = 100_000_000; // One time unit, 0.1 s
    localparam int unsigned TENTH_CYC     = TENTH_S_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int FW  = 16;  // Frequency, 0.01 Hz per lsb
    localparam int TW  = 16;  // Time, 0.1 s per lsb
    localparam int AW  = 36;  // Ramp accumulator width
    localparam int SW  = 23;  // Sub-tenth cycle counter width
    localparam int NT  = 5;   // Multi-function input terminals
    localparam int FNW = 6;   // Terminal function code width

    // ------------------------------------------------------------
    // Function codes, modes, limits
    // ------------------------------------------------------------
    localparam logic [FNW-1:0] FN_RUN_ENABLE = 6'h0D;  // Safe-run enable function
    localparam logic [1:0]     STOP_COAST    = 2'h0;   // Block output at once
    localparam logic [1:0]     STOP_QUICK    = 2'h1;   // Quick stop, fresh command
    localparam logic [1:0]     STOP_RESUME   = 2'h2;   // Quick stop, resume
    localparam logic [TW-1:0]  QSTOP_MAX     = 16'h1770; // 600.0 s
    localparam logic [TW-1:0]  ADWELL_MAX    = 16'h0064; // 10.0 s
    localparam logic [TW-1:0]  DDWELL_MAX    = 16'h0258; // 60.0 s

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [TW-1:0]  QSTOP_RST  = 16'h0032;  // 5.0 s
    localparam logic [FW-1:0]  DWELL_FRST = 16'h01F4;  // 5.00 Hz
    localparam logic [TW-1:0]  DWELL_TRST = 16'h0000;  // 0.0 s
    localparam logic [FW-1:0]  FMAX_RST   = 16'h1770;  // 60.00 Hz
    localparam logic [FW-1:0]  FSTART_RST = 16'h0032;  // 0.50 Hz
    localparam logic [TW-1:0]  RAMP_RST   = 16'h0032;  // 5.0 s

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;  // [1:0] stop mode, [2] safe select
    localparam logic [7:0] OFS_TFUNC  = 8'h04;  // Five 6-bit terminal functions
    localparam logic [7:0] OFS_TARGET = 8'h08;
    localparam logic [7:0] OFS_FMAX   = 8'h0C;
    localparam logic [7:0] OFS_FSTART = 8'h10;
    localparam logic [7:0] OFS_ACCT   = 8'h14;
    localparam logic [7:0] OFS_DECT   = 8'h18;
    localparam logic [7:0] OFS_QSTOPT = 8'h1C;
    localparam logic [7:0] OFS_ADFREQ = 8'h20;
    localparam logic [7:0] OFS_ADTIME = 8'h24;
    localparam logic [7:0] OFS_DDFREQ = 8'h28;
    localparam logic [7:0] OFS_DDTIME = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;  // Read only
    localparam int CTRL_SEL_BIT  = 2;
    localparam int ST_STATE_LSB  = 16;
    localparam int ST_DRIVE_BIT  = 20;
    localparam int ST_ENABLE_BIT = 21;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SRDR_STOP, SRDR_ACC, SRDR_ACC_HOLD, SRDR_RUN, SRDR_DEC,
        SRDR_DEC_HOLD, SRDR_DEC_POST, SRDR_QSTOP, SRDR_LOCK
    } srdr_state_t;

    typedef struct packed {
        logic [1:0]            stop_mode;
        logic                  safe_sel;
        logic [NT*FNW-1:0]     term_func;
        logic [FW-1:0]         target;
        logic [FW-1:0]         fmax;
        logic [FW-1:0]         fstart;
        logic [TW-1:0]         acc_time;
        logic [TW-1:0]         dec_time;
        logic [TW-1:0]         qstop_time;
        logic [FW-1:0]         adw_freq;
        logic [TW-1:0]         adw_time;
        logic [FW-1:0]         ddw_freq;
        logic [TW-1:0]         ddw_time;
    } srdr_cfg_t;

    typedef struct packed {
        logic          cyc;
        logic          stb;
        logic          we;
        logic [3:0]    sel;
        logic [7:0]    adr;
        logic [31:0]   dat;
    } srdr_wb_req_t;

endpackage

// ### srdr_top.sv
// Safe-run gating, disable stop modes and dwell frequency ramp
//
// The register addresses and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
module srdr_top
    import srdr_pkg::*;
#(
    parameter int unsigned TENTH_CYCLES = TENTH_CYC  // Cycles per 0.1 s
) (
    input  wire logic            clk_sys,
    input  wire logic            rst_b,
    input  wire srdr_wb_req_t    wb_req,
    output logic [31:0]          wb_dat_o,
    output logic                 wb_ack_o,
    input  wire logic            run_cmd,
    input  wire logic [NT-1:0]   multi_input_terminal,
    input  wire logic            ext_brake,
    output logic [FW-1:0]        freq_out,
    output logic                 drive_en
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = NT + 2;
    logic [PW-1:0] pin_s1_reg;  // First stage, read only by second
    logic [PW-1:0] pin_s2_reg;  // Second stage, safe to use

    // Two flops on every pin input
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= {ext_brake, run_cmd, multi_input_terminal};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    logic          run_s;     // Synchronised run command
    logic          brake_s;   // External brake control active
    logic [NT-1:0] term_s;    // Synchronised terminals
    assign {brake_s, run_s, term_s} = pin_s2_reg;  // Split second stage

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    srdr_cfg_t     cfg_reg, cfg_next;          // Software settings
    logic [31:0]   dat_reg, dat_next;          // Read data
    logic          ack_reg, ack_next;          // Bus acknowledge
    srdr_state_t   state_reg, state_next;      // Sequencer state
    logic [FW-1:0] freq_reg, freq_next;        // Output frequency
    logic          drv_reg, drv_next;          // Output enable
    logic [AW-1:0] acc_reg, acc_next;          // Ramp accumulator
    logic [TW-1:0] tenth_reg, tenth_next;      // Hold tenths left
    logic [SW-1:0] sub_reg, sub_next;          // Cycles in current tenth
    logic          run_d_reg, run_d_next;      // Run delayed, edge detect
    logic          arm_reg, arm_next;          // Acceleration dwell armed

    // ------------------------------------------------------------
    // Safe-run enable decode
    // ------------------------------------------------------------
    logic          en_cfg;    // Some terminal carries the enable function
    logic          en_term;   // A configured terminal is on
    logic          en_level;  // Effective enable
    logic          run_ok;    // Run command that may be acted on
    logic          run_rise;  // Fresh run command

    always_comb begin
        en_cfg  = 1'b0;
        en_term = 1'b0;
        for (int i = 0; i < NT; i++) begin
            if (cfg_reg.term_func[i*FNW +: FNW] == FN_RUN_ENABLE) begin
                en_cfg  = 1'b1;
                en_term = en_term | term_s[i];
            end
        end
        // Select 0 forces enable, select 1 follows the terminal if one carries the enable function, else enables
        en_level = !cfg_reg.safe_sel || !en_cfg || en_term;
        run_ok   = run_s && en_level;
        run_rise = run_s && !run_d_reg;
    end
    // ------------------------------------------------------------
    // Dwell frequency clamp and enables
    // ------------------------------------------------------------
    function automatic logic [FW-1:0] clamp_f(input logic [FW-1:0] f,
                                               input logic [FW-1:0] lo,
                                               input logic [FW-1:0] hi);
        return (f < lo) ? ((lo > hi) ? hi : lo) : ((f > hi) ? hi : f);
    endfunction
    logic [FW-1:0] adw_f;     // Clamped acceleration dwell frequency
    logic [FW-1:0] ddw_f;     // Clamped deceleration dwell frequency
    logic          adw_on;    // Acceleration dwell in use
    logic          ddw_on;    // Deceleration dwell in use

    always_comb begin
        adw_f  = clamp_f(cfg_reg.adw_freq, cfg_reg.fstart, cfg_reg.fmax);
        ddw_f  = clamp_f(cfg_reg.ddw_freq, cfg_reg.fstart, cfg_reg.fmax);
        adw_on = (cfg_reg.adw_time != '0) && (cfg_reg.adw_freq != '0);
        ddw_on = (cfg_reg.ddw_time != '0) && (cfg_reg.ddw_freq != '0);
    end

    // ------------------------------------------------------------
    // Wishbone slave, next values
    // ------------------------------------------------------------
    function automatic logic [TW-1:0] sat_t(input logic [TW-1:0] v, input logic [TW-1:0] hi);
        return (v > hi) ? hi : v;
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = wd[b*8 +: 8];
        end
        return r;
    endfunction
    always_comb begin
        logic        acc_cyc;
        logic [31:0] wv;
        acc_cyc  = wb_req.cyc && wb_req.stb && !ack_reg;
        wv       = '0;
        cfg_next = cfg_reg;
        dat_next = dat_reg;
        ack_next = acc_cyc;
        if (acc_cyc) begin
            // Read mux, unmapped offsets return zero
            unique case (wb_req.adr)
                OFS_CTRL:   dat_next = {29'h0, cfg_reg.safe_sel, cfg_reg.stop_mode};
                OFS_TFUNC:  dat_next = {2'h0, cfg_reg.term_func};
                OFS_TARGET: dat_next = {16'h0, cfg_reg.target};
                OFS_FMAX:   dat_next = {16'h0, cfg_reg.fmax};
                OFS_FSTART: dat_next = {16'h0, cfg_reg.fstart};
                OFS_ACCT:   dat_next = {16'h0, cfg_reg.acc_time};
                OFS_DECT:   dat_next = {16'h0, cfg_reg.dec_time};
                OFS_QSTOPT: dat_next = {16'h0, cfg_reg.qstop_time};
                OFS_ADFREQ: dat_next = {16'h0, cfg_reg.adw_freq};
                OFS_ADTIME: dat_next = {16'h0, cfg_reg.adw_time};
                OFS_DDFREQ: dat_next = {16'h0, cfg_reg.ddw_freq};
                OFS_DDTIME: dat_next = {16'h0, cfg_reg.ddw_time};
                OFS_STATUS: dat_next = {10'h0, en_level, drv_reg, 4'(state_reg), freq_reg};
                default:    dat_next = '0;
            endcase
            // Writes, with byte lanes and range saturation
            if (wb_req.we) begin
                wv = merge(dat_next, wb_req.dat, wb_req.sel);
                unique case (wb_req.adr)
                    OFS_CTRL: begin
                        // Stop mode range 0..2, 3 folds to coast
                        cfg_next.stop_mode = (wv[1:0] > STOP_RESUME) ? STOP_COAST : wv[1:0];
                        cfg_next.safe_sel  = wv[CTRL_SEL_BIT];
                    end
                    OFS_TFUNC:  cfg_next.term_func  = wv[NT*FNW-1:0];
                    OFS_TARGET: cfg_next.target     = wv[FW-1:0];
                    OFS_FMAX:   cfg_next.fmax       = wv[FW-1:0];
                    OFS_FSTART: cfg_next.fstart     = wv[FW-1:0];
                    OFS_ACCT:   cfg_next.acc_time   = wv[TW-1:0];
                    OFS_DECT:   cfg_next.dec_time   = wv[TW-1:0];
                    OFS_QSTOPT: cfg_next.qstop_time = sat_t(wv[TW-1:0], QSTOP_MAX);
                    OFS_ADFREQ: cfg_next.adw_freq   = wv[FW-1:0];
                    OFS_ADTIME: cfg_next.adw_time   = sat_t(wv[TW-1:0], ADWELL_MAX);
                    OFS_DDFREQ: cfg_next.ddw_freq   = wv[FW-1:0];
                    OFS_DDTIME: cfg_next.ddw_time   = sat_t(wv[TW-1:0], DDWELL_MAX);
                    default:    cfg_next = cfg_reg;
                endcase
            end
        end
    end
    // Bus registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_reg <= '{stop_mode: STOP_COAST, safe_sel: 1'b1, term_func: '0, target: '0,
                         fmax: FMAX_RST, fstart: FSTART_RST, acc_time: RAMP_RST,
                         dec_time: RAMP_RST, qstop_time: QSTOP_RST,
                         adw_freq: DWELL_FRST, adw_time: DWELL_TRST,
                         ddw_freq: DWELL_FRST, ddw_time: DWELL_TRST};
            dat_reg <= '0;
            ack_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            dat_reg <= dat_next;
            ack_reg <= ack_next;
        end
    end

    // ------------------------------------------------------------
    // Ramp engine and stop sequencer, next values
    // ------------------------------------------------------------
    always_comb begin
        logic [FW-1:0] goal;     // Frequency the ramp heads for
        logic [TW-1:0] rtime;    // Ramp time for full scale
        logic [AW-1:0] span;     // Cycles per lsb step times fmax
        logic [AW-1:0] sum;      // Accumulator plus fmax
        logic          hold_done;
        goal       = freq_reg;
        rtime      = cfg_reg.acc_time;
        span       = '0;
        sum        = '0;
        hold_done  = (tenth_reg == '0);
        state_next = state_reg;
        freq_next  = freq_reg;
        drv_next   = drv_reg;
        acc_next   = acc_reg;
        tenth_next = tenth_reg;
        sub_next   = sub_reg;
        run_d_next = run_s;
        arm_next   = run_rise ? 1'b1 : (run_s ? arm_reg : 1'b0);
        // Goal and ramp time per state
        unique case (state_reg)
            SRDR_STOP, SRDR_LOCK:    goal = '0;
            SRDR_ACC:      begin goal = adw_f; rtime = cfg_reg.acc_time; end
            SRDR_ACC_HOLD, SRDR_DEC_HOLD: goal = freq_reg;
            SRDR_RUN: begin  // Setpoint cuts ramp down without any dwell
                goal  = cfg_reg.target;
                rtime = (cfg_reg.target < freq_reg) ? cfg_reg.dec_time : cfg_reg.acc_time;
            end
            SRDR_DEC:      begin goal = ddw_f; rtime = cfg_reg.dec_time; end
            SRDR_DEC_POST: begin goal = '0; rtime = cfg_reg.dec_time; end
            SRDR_QSTOP:    begin goal = '0; rtime = cfg_reg.qstop_time; end
        endcase
        // Linear ramp, one lsb each time the accumulator passes span
        span = AW'(rtime) * AW'(TENTH_CYCLES);
        sum  = acc_reg + AW'(cfg_reg.fmax);
        if (freq_reg == goal) begin
            acc_next = '0;
        end else if (span == '0) begin
            freq_next = goal;
            acc_next  = '0;
        end else if (sum >= span) begin
            acc_next  = sum - span;
            freq_next = (goal > freq_reg) ? freq_reg + 1'b1 : freq_reg - 1'b1;
        end else begin
            acc_next  = sum;
        end
        // Dwell hold timer, counts tenths of a second
        if (sub_reg == SW'(TENTH_CYCLES - 1)) begin
            sub_next   = '0;
            tenth_next = hold_done ? tenth_reg : tenth_reg - 1'b1;
        end else begin
            sub_next   = sub_reg + 1'b1;
        end
        // Sequencer
        unique case (state_reg)
            SRDR_STOP: begin
                freq_next = '0;
                drv_next  = 1'b0;
                acc_next  = '0;
                if (run_ok) begin
                    drv_next   = 1'b1;
                    // Dwell only on a fresh command going past the dwell point
                    state_next = (adw_on && (arm_reg || run_rise) && cfg_reg.target > adw_f)
                               ? SRDR_ACC : SRDR_RUN;
                end
            end
            SRDR_ACC: begin
                if (freq_reg == adw_f) begin
                    state_next = SRDR_ACC_HOLD;
                    tenth_next = cfg_reg.adw_time;
                    sub_next   = '0;
                end
            end
            SRDR_ACC_HOLD: begin
                if (hold_done) begin
                    state_next = SRDR_RUN;
                    arm_next   = 1'b0;
                end
            end
            SRDR_RUN: ;
            SRDR_DEC: begin
                if (freq_reg == ddw_f) begin
                    state_next = SRDR_DEC_HOLD;
                    tenth_next = cfg_reg.ddw_time;
                    sub_next   = '0;
                end
            end
            SRDR_DEC_HOLD: if (hold_done) state_next = SRDR_DEC_POST;
            SRDR_DEC_POST: begin
                if (freq_reg == '0) begin
                    state_next = SRDR_STOP;
                    drv_next   = 1'b0;
                end
            end
            SRDR_QSTOP: begin
                if (freq_reg == '0) begin
                    state_next = SRDR_LOCK;
                    drv_next   = 1'b0;
                end
            end
            SRDR_LOCK: begin
                // Mode 1 needs a fresh command, mode 2 takes one held
                if (en_level && ((cfg_reg.stop_mode == STOP_RESUME) ? run_s : run_rise))
                    state_next = SRDR_STOP;
            end
        endcase
        // Stop command while running or accelerating
        if (!run_s && (state_reg == SRDR_ACC || state_reg == SRDR_ACC_HOLD ||
                       state_reg == SRDR_RUN)) begin
            state_next = (ddw_on && !brake_s && freq_reg > ddw_f)
                       ? SRDR_DEC : SRDR_DEC_POST;
        end
        // Run again during stop deceleration, no dwell
        if (run_s && (state_reg == SRDR_DEC || state_reg == SRDR_DEC_HOLD ||
                      state_reg == SRDR_DEC_POST)) begin
            state_next = SRDR_RUN;
            drv_next   = 1'b1;  // Output may just have been switched off at zero
        end
        // Enable drop overrides everything while running
        if (!en_level && state_reg != SRDR_STOP && state_reg != SRDR_LOCK &&
            state_reg != SRDR_QSTOP) begin
            acc_next = '0;
            if (cfg_reg.stop_mode == STOP_COAST) begin
                state_next = SRDR_STOP;
                freq_next  = '0;
                drv_next   = 1'b0;
            end else begin
                state_next = SRDR_QSTOP;
            end
        end
    end
    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= SRDR_STOP;
            freq_reg  <= '0;
            drv_reg   <= 1'b0;
            acc_reg   <= '0;
            tenth_reg <= '0;
            sub_reg   <= '0;
            run_d_reg <= 1'b0;
            arm_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            freq_reg  <= freq_next;
            drv_reg   <= drv_next;
            acc_reg   <= acc_next;
            tenth_reg <= tenth_next;
            sub_reg   <= sub_next;
            run_d_reg <= run_d_next;
            arm_reg   <= arm_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign freq_out = freq_reg;
    assign drive_en = drv_reg;
endmodule

// ### srdr_top_properties.sv
// Port checks of the safe-run dwell ramp block
`timescale 1ns/1ps
module srdr_top_properties
    import srdr_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          rst_b,
    input wire srdr_wb_req_t  wb_req,
    input wire logic [31:0]   wb_dat_o,
    input wire logic          wb_ack_o,
    input wire logic          run_cmd,
    input wire logic [NT-1:0] multi_input_terminal,
    input wire logic          ext_brake,
    input wire logic [FW-1:0] freq_out,
    input wire logic          drive_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_ack_one_shot: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held over two cycles");
    a_ack_answers: assert property (wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_req.cyc) && $past(wb_req.stb))
        else $error("ack without request");
    a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:30] == 2'h0)
        else $error("unused read bits set");
    a_reset_quiet: assert property ($rose(rst_b) |-> !drive_en && freq_out == 16'h0000)
        else $error("outputs active after reset");
    a_idle_freq_zero: assert property (
        !drive_en |-> freq_out == 16'h0000) else $error("frequency with output off");
    a_start_needs_run: assert property (
        $rose(drive_en) |-> $past(run_cmd, 2) || $past(run_cmd, 3))
        else $error("output started without run");
    a_rise_needs_drive: assert property (
        freq_out > $past(freq_out) |-> drive_en) else $error("ramp up with output off");
endmodule
bind srdr_top srdr_top_properties srdr_top_properties_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_cmd(run_cmd),
    .multi_input_terminal(multi_input_terminal), .ext_brake(ext_brake),
    .freq_out(freq_out), .drive_en(drive_en));

// ### srdr_operator.sv
// Operator side: run pin and input terminals
`timescale 1ns/1ps
module srdr_operator
    import srdr_pkg::*;
(
    input  wire logic    clk_sys,
    input  wire logic    want_run,
    input  wire logic    want_en,
    output logic         run_cmd,
    output logic [NT-1:0] multi_input_terminal
);
    // Pins change just after an edge, terminal 0 carries the enable
    always_ff @(posedge clk_sys) begin
        run_cmd <= want_run;
        multi_input_terminal <= {4'h0, want_en};
    end
endmodule

// ### tb_safe_run_dwell_ramp.sv
// Self-checking bench of the safe-run dwell ramp block
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %h got %h", nm, e, s); end end
module tb_safe_run_dwell_ramp;
    import srdr_pkg::*;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e;} srdr_row_t;
    logic clk_sys = 0;
    logic rst_b = 0;
    logic want_run = 0;
    logic want_en = 0;
    logic ext_brake = 0;
    logic run_cmd;
    logic [NT-1:0] multi_input_terminal;
    srdr_wb_req_t wreq = '0;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, drive_en;
    logic [FW-1:0] freq_out;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    srdr_row_t rows[15] = '{'{OFS_CTRL, 0, 0, 4}, '{OFS_FMAX, 0, 0, 32'h1770},
        '{OFS_FSTART, 0, 0, 32'h32}, '{OFS_QSTOPT, 0, 0, 32'h32}, '{OFS_ADFREQ, 0, 0, 32'h1F4},
        '{OFS_ADTIME, 0, 0, 0}, '{OFS_DDFREQ, 0, 0, 32'h1F4}, '{OFS_DDTIME, 0, 0, 0},
        '{8'h3C, 1, 32'hF, 0}, '{OFS_STATUS, 1, 32'hF, 32'h00200000},
        '{OFS_QSTOPT, 1, 32'hFFFF, 32'h1770}, '{OFS_QSTOPT, 1, 32'h32, 32'h32},
        '{OFS_ADTIME, 1, 32'hFFFF, 32'h64}, '{OFS_DDTIME, 1, 32'hFFFF, 32'h258},
        '{OFS_TFUNC, 1, 32'hD, 32'hD}};
    always #12.5 clk_sys = ~clk_sys;
    srdr_operator srdr_operator_i (.clk_sys(clk_sys), .want_run(want_run), .want_en(want_en),
        .run_cmd(run_cmd), .multi_input_terminal(multi_input_terminal));
    srdr_top #(.TENTH_CYCLES(10)) srdr_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .wb_req(wreq),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .run_cmd(run_cmd), .ext_brake(ext_brake),
        .multi_input_terminal(multi_input_terminal), .freq_out(freq_out), .drive_en(drive_en));
    // Classic single cycle, held until ack is sampled
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_sys);
        wreq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wreq <= '0;
    endtask
    task automatic pins(input logic r, input logic e, input int n);
        want_run <= r;
        want_en <= e;
        repeat (n + 1) @(posedge clk_sys);
    endtask
    task automatic waitf(input logic [FW-1:0] f, input int n);
        for (int k = 0; k < 4000 && freq_out !== f; k++) @(posedge clk_sys);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wb(rows[i].a, 1'b1, rows[i].d);
            wb(rows[i].a, 1'b0, 32'h0);
            `CHK("register", rows[i].e, q)
        end
        wb(OFS_ADTIME, 1'b1, 32'hA);
        wb(OFS_DDTIME, 1'b1, 32'hA);
        wb(OFS_TARGET, 1'b1, 32'h3E8);
        $display("register table done");
        pins(1, 0, 20);
        `CHK("refused run", 1'b0, drive_en)
        pins(0, 1, 5);
        pins(1, 1, 0);
        waitf(16'h01F4, 50);
        `CHK("accel dwell", 16'h01F4, freq_out)
        waitf(16'h03E8, 0);
        pins(1, 0, 6);
        `CHK("coast", 2'b00, {drive_en, |freq_out})
        wb(OFS_CTRL, 1'b1, 32'h5);
        pins(0, 1, 5);
        pins(1, 1, 0);
        waitf(16'h03E8, 0);
        pins(1, 0, 20);
        `CHK("quick stop", 1'b1, drive_en)
        waitf(16'h0000, 0);
        pins(1, 1, 30);
        `CHK("no restart", 1'b0, drive_en)
        pins(0, 1, 5);
        pins(1, 1, 10);
        `CHK("fresh run", 1'b1, drive_en)
        $display("stop modes 0 and 1 done");
        waitf(16'h03E8, 0);
        wb(OFS_CTRL, 1'b1, 32'h6);
        pins(1, 0, 0);
        waitf(16'h0000, 0);
        pins(1, 1, 0);
        waitf(16'h01F4, 50);
        `CHK("resume no dwell", 1'b1, freq_out > 16'h01F4)
        waitf(16'h03E8, 0);
        pins(0, 1, 0);
        waitf(16'h01F4, 50);
        `CHK("decel dwell", 16'h01F4, freq_out)
        waitf(16'h0000, 5);
        `CHK("stopped", 1'b0, drive_en)
        $display("mode 2 and dwell done");
        wb(OFS_ADTIME, 1'b1, 32'h0);
        ext_brake <= 1'b1;
        pins(1, 1, 0);
        waitf(16'h01F4, 50);
        `CHK("zero time", 1'b1, freq_out > 16'h01F4)
        waitf(16'h03E8, 0);
        pins(0, 1, 0);
        waitf(16'h01F4, 50);
        `CHK("brake no dwell", 1'b1, freq_out < 16'h01F4)
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("in reset", 2'b00, {drive_en, |freq_out})
        rst_b <= 1'b1;
        wb(OFS_CTRL, 1'b0, 32'h0);
        `CHK("reset ctrl", 32'h4, q)
        $display("dwell skips and reset done");
        conclude();
    end
endmodule
